/* eeps_ifs.sv */
// Purpose: Carriers between the slave core, its line front end and memory.
// Assumes: All members live in the system clock domain.
// Notes: Line events are one-cycle pulses.
interface eeps_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [2:0] cs;
  logic wp;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop, cs, wp);
  modport snk (input scl, sda, scl_rise, scl_fall, start, stop, cs, wp);
endinterface

interface eeps_mem_if;
  logic wr_en;
  logic wr_id;
  logic [eeps_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_id;
  logic [eeps_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctl (output wr_en, wr_id, wr_addr, wr_data, rd_id, rd_addr,
               input rd_data);
  modport mem (input wr_en, wr_id, wr_addr, wr_data, rd_id, rd_addr,
               output rd_data);
endinterface

/* eeps_master_model.sv */
// Purpose: Behavioural bus master facing the serial EEPROM slave.
// Assumes: Tasks are entered just after a rising clk edge.
// Notes: 4 clk per clock half (80 ns); clock stands high between frames.
module eeps_master_model (
  input wire logic clk, // System clock
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock
  output logic sda_drv // Data drive, 1 releases to the pull-up
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid-low so the slave always sees the clock fall first
  task automatic bt(input logic b, output logic r);
    scl <= 1'b0;
    tk(2);
    sda_drv <= b;
    tk(2);
    scl <= 1'b1;
    tk(2);
    r = sda;
    tk(2);
  endtask
  task automatic start();
    scl <= 1'b0;
    tk(4);
    sda_drv <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_drv <= 1'b0;
    tk(4);
  endtask
  task automatic stop();
    scl <= 1'b0;
    tk(2);
    sda_drv <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_drv <= 1'b1;
    tk(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(d[i], r);
    bt(1'b1, r);
    ack = (r === 1'b0);
  endtask
  // Acknowledge asks for another byte; releasing ends the read
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(1'b1, d[i]);
    bt(~mack, r);
  endtask
endmodule // eeps_master_model

/* eeps_mem.sv */
// Purpose: Main array and identification page held in flip-flops.
// Assumes: One write and one combinational read port.
// Notes: Contents are not reset; only power-up state is undefined.
module eeps_mem #(
  parameter int DEPTH = 2 ** eeps_pkg::ADDR_W, // Main array bytes
  parameter int ID_DEPTH = 2 ** eeps_pkg::ID_W // Identification page bytes
) (
  input wire logic clk, // System clock
  eeps_mem_if.mem mif // Read and write port
);
  logic [7:0] main_q [DEPTH];
  logic [7:0] id_q [ID_DEPTH];

  always_ff @(posedge clk)
  begin
    if (mif.wr_en && mif.wr_id)
      id_q[mif.wr_addr[eeps_pkg::ID_W-1:0]] <= mif.wr_data;
    else if (mif.wr_en)
      main_q[mif.wr_addr] <= mif.wr_data;
  end

  assign mif.rd_data = mif.rd_id ? id_q[mif.rd_addr[eeps_pkg::ID_W-1:0]]
                                 : main_q[mif.rd_addr];
endmodule // eeps_mem

/* eeps_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM slave.
// Assumes: 50 MHz system clock; bus lines sampled, never used as clocks.
// Notes: Device code and bit positions follow the two-wire address format.
package eeps_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int T_WR_MS = 5;
  // Longest time, so the count rounds down
  localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / 1000);

  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int ID_W = 4;
  localparam int SYNC_W = 6;

  localparam logic [2:0] DEV_CODE = 3'h5;
  localparam int TYPE_BIT = 4;
  localparam int RW_BIT = 0;
  localparam int HI_LOCK_BIT = 2;
  localparam int HI_SN_BIT = 3;
  localparam int LOCK_DATA_BIT = 1;

  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  localparam logic [ADDR_W-1:0] PTR_RST = 14'h0000;
  localparam logic LOCK_RST = 1'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } eeps_state_t;
endpackage

/* eeps_slave.sv */
// Purpose: Two-wire EEPROM slave: addressing, writes, reads, ID page, lock.
// Assumes: SCL and SDA arrive as pins; SDA is open drain, driven low only.
// Notes: Bytes land in the array as taken; the timed cycle only models busy.

// Contract
// - Data changing while clock high is a start or stop, never a bit.
// - Data falling while clock high is a start; it opens every command.
// - Data rising while clock high is a stop, honoured in any state.
// - Bytes are eight bits; device pulls data low on the ninth clock.
// - Standby after power-up, after a stop, after programming ends.
// - Start, nine ones, start, stop leaves the device ready again.
// - Address after start has code 1010 for array, 1011 for ID area.
// - Address bits 3..1 must equal the three chip-select pins.
// - Address bit 0 high means read, low means write.
// - Matching address is acknowledged; otherwise silent, back to standby.
// - Write-protect pin high blocks every change of the main array.
// - Byte write: address, two word bytes, data, stop starts programming.
// - During programming all bus inputs are ignored, no response given.
// - Page write keeps taking acknowledged data bytes until a stop.
// - Only the low six address bits step; wraps inside the page.
// - Polling address gets no acknowledge until programming is done.
// - ID page write uses code 1011, bits 11..10 zero, index bits 3..0.
// - Locked ID page refuses data bytes with no acknowledge, unchanged.
// - Lock command: code 1011, bit 10 set, data bit 1 set; permanent.
// - Pointer steps after each byte and wraps at the array end.
// - Current read: acknowledge read address, send byte at pointer.
// - Random read: dummy write of address, repeated start, then read.
// - Programming ends within 5 ms of the stop ending a write.
// - Master acknowledge fetches the next byte; no acknowledge ends it.
module eeps_slave #(
  parameter int WR_CYCLES = eeps_pkg::WR_CYCLES // Programming window cycles
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Data pin output value, always low
  output logic sda_oe_n, // Low while pulling data low
  input wire logic chip_select_bit_low, // Address strap bit 1
  input wire logic chip_select_bit_mid, // Address strap bit 2
  input wire logic chip_select_bit_high, // Address strap bit 3
  input wire logic write_protect_pin, // High blocks array writes
  output logic write_busy, // Timed write cycle running
  output logic standby, // Idle with no programming
  output logic id_locked // ID page permanently read-only
);
  localparam int AW = eeps_pkg::ADDR_W;
  localparam int PW = eeps_pkg::PAGE_W;
  localparam int CW = $clog2(WR_CYCLES + 1);
  localparam logic [CW-1:0] WR_LOAD = CW'(WR_CYCLES - 1);

  eeps_line_if line ();
  eeps_mem_if mif ();
  eeps_pkg::eeps_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic full_q, full_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic id_sel_q, id_sel_d;
  logic rw_q, rw_d;
  logic [7:0] hi_q, hi_d;
  logic [AW-1:0] ptr_q, ptr_d;
  logic oe_n_q, oe_n_d;
  logic wr_pend_q, wr_pend_d;
  logic lock_pend_q, lock_pend_d;
  logic locked_q, locked_d;
  logic busy_q, busy_d;
  logic [CW-1:0] wcnt_q, wcnt_d;
  logic standby_q;
  logic sda_out_q;
  logic load_v;

  eeps_sync u_sync (
    .clk (clk),
    .nrst (nrst),
    .pins ({write_protect_pin, chip_select_bit_high, chip_select_bit_mid,
            chip_select_bit_low, sda_in, scl_in}),
    .line (line)
  );

  eeps_mem u_mem (
    .clk (clk),
    .mif (mif)
  );

  wire quiet_w = !busy_q && !line.stop && !line.start;
  wire dec_w = (state_q == eeps_pkg::ST_RX) && full_q && line.scl_fall
               && quiet_w;
  wire data_w = dec_w && (idx_q == eeps_pkg::IDX_DATA);
  wire match_w = (sh_q[7:5] == eeps_pkg::DEV_CODE)
                 && (sh_q[3:1] == line.cs);
  wire lock_cmd_w = id_sel_q && hi_q[eeps_pkg::HI_LOCK_BIT];
  // Serial-number rows take no writes; locked page takes none at all
  wire id_bad_w = locked_q || (!hi_q[eeps_pkg::HI_LOCK_BIT]
                  && hi_q[eeps_pkg::HI_SN_BIT]);
  wire data_ack_w = !id_sel_q || !id_bad_w;
  wire lock_set_w = data_w && lock_cmd_w && data_ack_w
                    && sh_q[eeps_pkg::LOCK_DATA_BIT];
  wire [AW-1:0] page_next_w = {ptr_q[AW-1:PW],
                               ptr_q[PW-1:0] + PW'(1)};

  assign mif.wr_en = data_w && data_ack_w && !lock_cmd_w
                     && (id_sel_q || !line.wp);
  assign mif.wr_id = id_sel_q;
  assign mif.wr_addr = ptr_q;
  assign mif.wr_data = sh_q;
  assign mif.rd_id = id_sel_q;
  assign mif.rd_addr = ptr_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    full_d = full_q;
    idx_d = idx_q;
    sh_d = sh_q;
    tx_d = tx_q;
    id_sel_d = id_sel_q;
    rw_d = rw_q;
    hi_d = hi_q;
    ptr_d = ptr_q;
    oe_n_d = oe_n_q;
    wr_pend_d = wr_pend_q;
    lock_pend_d = lock_pend_q;
    locked_d = locked_q;
    busy_d = busy_q;
    wcnt_d = wcnt_q;
    load_v = 1'h0;
    if (busy_q)
    begin
      // Deaf while programming, so a polling address sees no acknowledge
      state_d = eeps_pkg::ST_IDLE;
      oe_n_d = 1'h1;
      if (wcnt_q == '0)
        busy_d = 1'h0;
      else
        wcnt_d = wcnt_q - CW'(1);
    end
    else if (line.stop)
    begin
      state_d = eeps_pkg::ST_IDLE;
      oe_n_d = 1'h1;
      if (wr_pend_q)
      begin
        busy_d = 1'h1;
        wcnt_d = WR_LOAD;
      end
      if (lock_pend_q)
        locked_d = 1'h1;
      wr_pend_d = 1'h0;
      lock_pend_d = 1'h0;
    end
    else if (line.start)
    begin
      // Any start, repeated or not, restarts address reception
      state_d = eeps_pkg::ST_RX;
      idx_d = eeps_pkg::IDX_DEV;
      cnt_d = 3'h0;
      full_d = 1'h0;
      oe_n_d = 1'h1;
    end
    else
    begin
      case (state_q)
        eeps_pkg::ST_RX:
        begin
          if (line.scl_rise && !full_q)
          begin
            sh_d = {sh_q[6:0], line.sda};
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == eeps_pkg::BIT_LAST);
          end
          else if (dec_w)
          begin
            full_d = 1'h0;
            cnt_d = 3'h0;
            idx_d = (idx_q == eeps_pkg::IDX_DATA) ? eeps_pkg::IDX_DATA
                                                 : idx_q + 2'h1;
            state_d = eeps_pkg::ST_ACK;
            oe_n_d = 1'h0;
            if (idx_q == eeps_pkg::IDX_DEV)
            begin
              id_sel_d = sh_q[eeps_pkg::TYPE_BIT];
              rw_d = sh_q[eeps_pkg::RW_BIT];
              if (!match_w)
              begin
                state_d = eeps_pkg::ST_IDLE;
                oe_n_d = 1'h1;
              end
            end
            else if (idx_q == eeps_pkg::IDX_HI)
              hi_d = sh_q;
            else if (idx_q == eeps_pkg::IDX_LO)
              ptr_d = {hi_q[AW-9:0], sh_q};
            else if (!data_ack_w)
            begin
              state_d = eeps_pkg::ST_IDLE;
              oe_n_d = 1'h1;
            end
            else
            begin
              ptr_d = page_next_w;
              wr_pend_d = wr_pend_q | mif.wr_en | lock_set_w;
              lock_pend_d = lock_pend_q | lock_set_w;
            end
          end
        end
        eeps_pkg::ST_ACK:
        begin
          if (line.scl_fall && rw_q)
            load_v = 1'h1;
          else if (line.scl_fall)
          begin
            state_d = eeps_pkg::ST_RX;
            oe_n_d = 1'h1;
          end
        end
        eeps_pkg::ST_TX:
        begin
          if (line.scl_rise && !full_q)
          begin
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == eeps_pkg::BIT_LAST);
          end
          else if (line.scl_fall && full_q)
          begin
            state_d = eeps_pkg::ST_MACK;
            full_d = 1'h0;
            oe_n_d = 1'h1;
          end
          else if (line.scl_fall)
          begin
            tx_d = {tx_q[6:0], 1'h0};
            oe_n_d = tx_q[6];
          end
        end
        eeps_pkg::ST_MACK:
        begin
          if (line.scl_rise && !full_q && !line.sda)
            full_d = 1'h1;
          else if (line.scl_rise && !full_q)
            state_d = eeps_pkg::ST_IDLE;
          else if (line.scl_fall && full_q)
            load_v = 1'h1;
        end
        default:
        begin
          state_d = eeps_pkg::ST_IDLE;
          oe_n_d = 1'h1;
        end
      endcase
      if (load_v)
      begin
        // Fetch at the pointer, then step it over the whole array
        state_d = eeps_pkg::ST_TX;
        tx_d = mif.rd_data;
        oe_n_d = mif.rd_data[7];
        cnt_d = 3'h0;
        full_d = 1'h0;
        ptr_d = ptr_q + AW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= eeps_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      full_q <= 1'h0;
      idx_q <= eeps_pkg::IDX_DEV;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      id_sel_q <= 1'h0;
      rw_q <= 1'h0;
      hi_q <= 8'h00;
      ptr_q <= eeps_pkg::PTR_RST;
      oe_n_q <= 1'h1;
      wr_pend_q <= 1'h0;
      lock_pend_q <= 1'h0;
      locked_q <= eeps_pkg::LOCK_RST;
      busy_q <= 1'h0;
      wcnt_q <= '0;
      standby_q <= 1'h1;
      sda_out_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      id_sel_q <= id_sel_d;
      rw_q <= rw_d;
      hi_q <= hi_d;
      ptr_q <= ptr_d;
      oe_n_q <= oe_n_d;
      wr_pend_q <= wr_pend_d;
      lock_pend_q <= lock_pend_d;
      locked_q <= locked_d;
      busy_q <= busy_d;
      wcnt_q <= wcnt_d;
      standby_q <= (state_d == eeps_pkg::ST_IDLE) && !busy_d;
      sda_out_q <= 1'h0;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_n = oe_n_q;
  assign write_busy = busy_q;
  assign standby = standby_q;
  assign id_locked = locked_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence mack_ok_s;
    (state_q == eeps_pkg::ST_MACK) && line.scl_rise && !full_q
    && !line.sda && quiet_w;
  endsequence
  sequence refetch_s;
    (state_q == eeps_pkg::ST_MACK) && full_q && line.scl_fall && quiet_w;
  endsequence

  busy_quiet_a: assert property (busy_q |=> oe_n_q)
    else $error("data line driven during write cycle");
  start_addr_a: assert property (line.start && !busy_q && !line.stop
    |=> (state_q == eeps_pkg::ST_RX) && (idx_q == eeps_pkg::IDX_DEV))
    else $error("start did not open address reception");
  stop_idle_a: assert property (line.stop |=> (state_q == eeps_pkg::ST_IDLE)
    && oe_n_q)
    else $error("stop did not return to idle");
  ack_drive_a: assert property ((state_q == eeps_pkg::ST_ACK)
    |-> !oe_n_q)
    else $error("acknowledge slot not driven low");
  addr_miss_a: assert property (dec_w && (idx_q == eeps_pkg::IDX_DEV)
    && !match_w |=> (state_q == eeps_pkg::ST_IDLE) && oe_n_q)
    else $error("mismatched address was acknowledged");
  wp_block_a: assert property (mif.wr_en && !mif.wr_id |-> !line.wp)
    else $error("array written while protected");
  lock_block_a: assert property (mif.wr_en && mif.wr_id
    |-> !locked_q)
    else $error("locked ID page written");
  page_wrap_a: assert property (mif.wr_en |=>
    (ptr_q[AW-1:PW] == $past(ptr_q[AW-1:PW]))
    && (ptr_q[PW-1:0] == PW'($past(ptr_q[PW-1:0]) + 1)))
    else $error("write pointer left its page");
  wr_start_a: assert property (line.stop && !busy_q && wr_pend_q
    |=> busy_q && (wcnt_q == WR_LOAD))
    else $error("write cycle not started with full count");
  wr_end_a: assert property (busy_q && (wcnt_q == '0) |=> !busy_q
    ##1 !busy_q)
    else $error("write cycle overran");
  seq_next_a: assert property (mack_ok_s |=> full_q
    && (state_q == eeps_pkg::ST_MACK))
    else $error("master acknowledge not taken");
  seq_fetch_a: assert property (refetch_s |=> (state_q == eeps_pkg::ST_TX)
    && (ptr_q == AW'($past(ptr_q) + 1)))
    else $error("read did not fetch next byte");
  fall_drive_a: assert property ($fell(oe_n_q)
    |-> $past(line.scl_fall))
    else $error("data driven low away from clock fall");
endmodule // eeps_slave

/* eeps_slave_tb.sv */
// Purpose: Self-checking bench of the serial EEPROM slave.
// Assumes: Straps at 101, so addresses are AA/AB (array), BA/BB (ID).
// Notes: Short timed write cycle keeps the run brief.
module eeps_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR = 200;
  localparam logic [7:0] AW = 8'hAA;
  localparam logic [7:0] AR = 8'hAB;
  localparam logic [7:0] IW = 8'hBA;
  logic clk = 1'b0;
  logic nrst;
  logic wp;
  logic [2:0] cs;
  logic scl;
  logic sda_drv;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  logic write_busy;
  logic standby;
  logic id_locked;
  int error_cnt = 0;
  int samples_checked = 0;
  // Open drain with pull-up: a released line reads high
  assign sda = sda_drv & (sda_oe_n | sda_out);
  always #10 clk = ~clk;
  eeps_slave #(.WR_CYCLES(WR)) eeps_slave_i (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_select_bit_low(cs[0]), .chip_select_bit_mid(cs[1]),
    .chip_select_bit_high(cs[2]), .write_protect_pin(wp),
    .write_busy(write_busy), .standby(standby), .id_locked(id_locked)
  );
  eeps_master_model eeps_master_model_i (
    .clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv)
  );
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic st();
    eeps_master_model_i.start();
  endtask
  task automatic sp();
    eeps_master_model_i.stop();
  endtask
  task automatic sb(input logic [7:0] d, input logic e);
    logic a;
    eeps_master_model_i.wbyte(d, a);
    chk1(a, e);
  endtask
  task automatic rd(input logic [7:0] e, input logic mack);
    logic [7:0] d;
    eeps_master_model_i.rbyte(mack, d);
    chk(d, e);
  endtask
  task automatic hdr(input logic [7:0] dv, input logic [7:0] hi,
                     input logic [7:0] lo);
    st();
    sb(dv, 1'b1);
    sb(hi, 1'b1);
    sb(lo, 1'b1);
  endtask
  // Dummy write of the address, repeated start, one byte back
  task automatic rnd(input logic [7:0] dv, input logic [7:0] hi,
                     input logic [7:0] lo, input logic [7:0] e);
    hdr(dv, hi, lo);
    st();
    sb(dv | 8'h01, 1'b1);
    rd(e, 1'b0);
    sp();
  endtask
  // Stop, poll while busy, then wait out the timed cycle
  task automatic endw();
    int n;
    sp();
    chk1(write_busy, 1'b1);
    st();
    sb(AW, 1'b0);
    sp();
    n = 0;
    while (write_busy !== 1'b0 && n < WR)
    begin
      tk(1);
      n++;
    end
    chk1(write_busy, 1'b0);
    chk1(standby, 1'b1);
  endtask
  task automatic t_reset();
    chk1(sda_oe_n, 1'b1);
    chk1(sda_out, 1'b0);
    chk1(write_busy, 1'b0);
    chk1(standby, 1'b1);
    chk1(id_locked, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_byte();
    hdr(AW, 8'hFF, 8'hFF);
    sb(8'h5A, 1'b1);
    endw();
    hdr(AW, 8'h00, 8'h00);
    sb(8'hC3, 1'b1);
    endw();
    hdr(AW, 8'h3F, 8'hFF);
    st();
    sb(AR, 1'b1);
    rd(8'h5A, 1'b1);
    rd(8'hC3, 1'b0);
    sp();
    chk1(standby, 1'b1);
    $display("byte write and sequential read test done");
  endtask
  task automatic t_page();
    hdr(AW, 8'h01, 8'h3E);
    sb(8'h11, 1'b1);
    sb(8'h22, 1'b1);
    sb(8'h33, 1'b1);
    endw();
    rnd(AW, 8'h01, 8'h3E, 8'h11);
    st();
    sb(AR, 1'b1);
    rd(8'h22, 1'b0);
    sp();
    rnd(AW, 8'h01, 8'h00, 8'h33);
    $display("page write test done");
  endtask
  task automatic t_wp();
    wp <= 1'b1;
    hdr(AW, 8'h01, 8'h3E);
    sb(8'hEE, 1'b1);
    sp();
    tk(4);
    chk1(write_busy, 1'b0);
    wp <= 1'b0;
    rnd(AW, 8'h01, 8'h3E, 8'h11);
    $display("write protect test done");
  endtask
  task automatic t_addr();
    st();
    sb(8'hA8, 1'b0);
    sp();
    st();
    sb(8'h9A, 1'b0);
    sp();
    chk1(standby, 1'b1);
    $display("address match test done");
  endtask
  task automatic t_id();
    hdr(IW, 8'h00, 8'h05);
    sb(8'h33, 1'b1);
    endw();
    rnd(IW, 8'h00, 8'h05, 8'h33);
    // Serial-number rows are not writable: the data byte is refused
    hdr(IW, 8'h08, 8'h00);
    sb(8'h55, 1'b0);
    sp();
    // Lock data with bit 1 clear is taken but changes nothing
    hdr(IW, 8'h04, 8'h00);
    sb(8'hFD, 1'b1);
    sp();
    chk1(write_busy, 1'b0);
    chk1(id_locked, 1'b0);
    hdr(IW, 8'h04, 8'h00);
    sb(8'h02, 1'b1);
    endw();
    chk1(id_locked, 1'b1);
    hdr(IW, 8'h00, 8'h05);
    sb(8'h44, 1'b0);
    sp();
    rnd(IW, 8'h00, 8'h05, 8'h33);
    $display("id page and lock test done");
  endtask
  task automatic t_soft();
    logic r;
    hdr(AW, 8'h01, 8'h3E);
    repeat (3) eeps_master_model_i.bt(1'b0, r);
    st();
    repeat (9) eeps_master_model_i.bt(1'b1, r);
    st();
    sp();
    st();
    sb(AR, 1'b1);
    rd(8'h11, 1'b0);
    sp();
    $display("soft reset test done");
  endtask
  initial
  begin
    nrst = 1'b0;
    wp = 1'b0;
    cs = 3'b101;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    tk(6);
    t_reset();
    t_byte();
    t_page();
    t_wp();
    t_addr();
    t_id();
    t_soft();
    end_sim();
  end
  initial
  begin
    #1_000_000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule // eeps_slave_tb

/* eeps_sync.sv */
// Purpose: Synchronise bus pins and straps, find clock edges, start, stop.
// Assumes: Pins are asynchronous to clk; slow enough for edge sampling.
// Notes: Only the second stage feeds any logic.
module eeps_sync (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [eeps_pkg::SYNC_W-1:0] pins, // {wp,cs[2:0],sda,scl}
  eeps_line_if.src line // Synchronised levels and events
);
  logic [eeps_pkg::SYNC_W-1:0] s1_q;
  logic [eeps_pkg::SYNC_W-1:0] s2_q;
  logic scl_p_q;
  logic sda_p_q;

  genvar i;
  generate
    for (i = 0; i < eeps_pkg::SYNC_W; i++)
    begin : g_sync
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_q[i] <= 1'h1;
          s2_q[i] <= 1'h1;
        end
        else
        begin
          s1_q[i] <= pins[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end
    else
    begin
      scl_p_q <= s2_q[0];
      sda_p_q <= s2_q[1];
    end
  end

  assign line.scl = s2_q[0];
  assign line.sda = s2_q[1];
  assign line.cs = s2_q[4:2];
  assign line.wp = s2_q[5];
  assign line.scl_rise = s2_q[0] & ~scl_p_q;
  assign line.scl_fall = ~s2_q[0] & scl_p_q;
  // Data moving while the clock stays high is a condition, not a bit
  assign line.start = s2_q[0] & scl_p_q & sda_p_q & ~s2_q[1];
  assign line.stop = s2_q[0] & scl_p_q & ~sda_p_q & s2_q[1];
endmodule // eeps_sync
